// [uotg_defs.vh]
// Register offsets, field positions, reset values and timing counts.
`ifndef UOTG_DEFS_VH
`define UOTG_DEFS_VH
// Register word offsets on the plain register port.
`define UOTG_ADDR_W 4
`define UOTG_OFS_STATUS 4'h0
`define UOTG_OFS_CONTROL 4'h1
`define UOTG_OFS_POWER 4'h2
`define UOTG_OFS_CONFIG2 4'h3
`define UOTG_OFS_OTG_IRQ 4'h4
`define UOTG_OFS_USB_IRQ 4'h5
`define UOTG_OFS_BDT_PAGE 4'h6
`define UOTG_OFS_FRAME_LO 4'h7
`define UOTG_OFS_FRAME_HI 4'h8
`define UOTG_OFS_PWM_RRS 4'h9
`define UOTG_OFS_PWM_CON 4'hA
// Status register fields.
`define UOTG_ST_ID 7
`define UOTG_ST_LSTABLE 5
`define UOTG_ST_SESS_VALID 3
`define UOTG_ST_SESS_END 2
`define UOTG_ST_VBUS_VALID 0
// Control register fields.
`define UOTG_CT_DP_PULLUP 7
`define UOTG_CT_DM_PULLUP 6
`define UOTG_CT_DP_PULLDN 5
`define UOTG_CT_DM_PULLDN 4
`define UOTG_CT_VBUS_ON 3
`define UOTG_CT_OTG_EN 2
`define UOTG_CT_VBUS_CHG 1
`define UOTG_CT_VBUS_DIS 0
// Configuration register 2 fields.
`define UOTG_CF_CMP_SEL 5
`define UOTG_CF_VBUS_PULSE 4
`define UOTG_CF_CMP_DIS 1
// Interrupt flag fields.
`define UOTG_OI_SESS_VALID 3
`define UOTG_OI_SESS_END 2
`define UOTG_UI_ATTACH 6
`define UOTG_UI_BUS_RESET 0
// Power control writable bits and reset values.
`define UOTG_PWR_MASK 8'h93
`define UOTG_RST_BYTE 8'h00
`define UOTG_RST_WORD 16'h0000
// Timing: clock rate and stable-time for the line state.
`define UOTG_CLK_HZ 100000000
`define UOTG_LSTABLE_US 1000
`define UOTG_LSTABLE_CYC ((`UOTG_CLK_HZ / 1000000) * `UOTG_LSTABLE_US)
`endif

// [uotg_session_ctl.v]
// OTG session and role control: comparator inputs, status, control regs.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`include "uotg_defs.vh"

module uotg_session_ctl (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire int_vbus_valid,
    input wire int_session_valid,
    input wire int_session_end,
    input wire comparator_status_1,
    input wire comparator_status_2,
    input wire ext_vbus_valid_in,
    input wire ext_session_valid_in,
    input wire ext_session_end_in,
    input wire id_pin,
    input wire line_se0,
    input wire line_jstate,
    input wire attach_event,
    input wire bus_reset_event,
    output reg dplus_pullup_en,
    output reg dminus_pullup_en,
    output reg dplus_pulldown_en,
    output reg dminus_pulldown_en,
    output reg vbus_power_on,
    output reg otg_features_en,
    output reg vbus_charge_select,
    output reg vbus_discharge_en,
    output reg vbus_pulse_en,
    output reg internal_comparator_disable
);

////////////////////////////////////////////////////////////////////////////
// Three-stage synchronisers for every asynchronous input.

localparam NSYNC = 12;
wire [NSYNC-1:0] async_in;
reg [NSYNC-1:0] sync_a;
reg [NSYNC-1:0] sync_b;
reg [NSYNC-1:0] sync_c;
reg [NSYNC-1:0] stable;

assign async_in = {bus_reset_event, attach_event, line_jstate, line_se0,
    id_pin, ext_session_end_in, ext_session_valid_in, ext_vbus_valid_in,
    comparator_status_2, comparator_status_1, int_session_end,
    int_session_valid};

// A change is accepted only when the second and third stage agree.
// Status input synchronising.
always @(posedge clk) begin
    if (sys_rst) begin
        sync_a <= {NSYNC{1'b0}};
        sync_b <= {NSYNC{1'b0}};
        sync_c <= {NSYNC{1'b0}};
        stable <= {NSYNC{1'b0}};
    end else begin
        sync_a <= async_in;
        sync_b <= sync_a;
        sync_c <= sync_b;
        stable <= (sync_b & sync_c) | (stable & (sync_b | sync_c));
    end
end

// Internal VBUS-valid comparator runs through its own synchroniser.
reg vv_a;
reg vv_b;
reg vv_c;
reg vv_s;
always @(posedge clk) begin
    if (sys_rst) begin
        vv_a <= 1'b0;
        vv_b <= 1'b0;
        vv_c <= 1'b0;
        vv_s <= 1'b0;
    end else begin
        vv_a <= int_vbus_valid;
        vv_b <= vv_a;
        vv_c <= vv_b;
        vv_s <= (vv_b & vv_c) | (vv_s & (vv_b | vv_c));
    end
end

wire s_int_sv = stable[0];
wire s_int_se = stable[1];
wire s_cst1 = stable[2];
wire s_cst2 = stable[3];
wire s_ext_vv = stable[4];
wire s_ext_sv = stable[5];
wire s_ext_se = stable[6];
wire s_id = stable[7];
wire s_se0 = stable[8];
wire s_jst = stable[9];
wire s_attach = stable[10];
wire s_busrst = stable[11];

////////////////////////////////////////////////////////////////////////////
// Comparator source selection.

reg cmp_select;
reg cmp_vbus_valid;
reg cmp_sess_valid;
reg cmp_sess_end;

// Internal, two-pin or three-pin decode.
// Two-pin mode only gives bands, so each flag is derived from the band.
always @* begin
    if (!internal_comparator_disable) begin
        cmp_vbus_valid = vv_s;
        cmp_sess_valid = s_int_sv;
        cmp_sess_end = s_int_se;
    end else if (!cmp_select) begin
        cmp_vbus_valid = s_cst1 & s_cst2;
        cmp_sess_valid = s_cst2;
        cmp_sess_end = ~s_cst1 & ~s_cst2;
    end else begin
        cmp_vbus_valid = s_ext_vv;
        cmp_sess_valid = s_ext_sv | s_ext_vv;
        cmp_sess_end = s_ext_se;
    end
end

////////////////////////////////////////////////////////////////////////////
// Line-state stability timer.

reg [1:0] last_line;
reg [16:0] line_cnt;
reg line_stable;
wire [1:0] cur_line = {s_se0, s_jst};

// Any change of the SE0/J pair restarts the 1 ms window.
// Line stable timer.
always @(posedge clk) begin
    if (sys_rst) begin
        last_line <= 2'h0;
        line_cnt <= 17'h00000;
        line_stable <= 1'b0;
    end else if (cur_line != last_line) begin
        last_line <= cur_line;
        line_cnt <= 17'h00000;
        line_stable <= 1'b0;
    end else if (line_cnt == `UOTG_LSTABLE_CYC - 1) begin
        line_stable <= 1'b1;
    end else begin
        line_cnt <= line_cnt + 17'h00001;
    end
end

////////////////////////////////////////////////////////////////////////////
// Sticky event flags; a new event wins over a software clear.

reg [7:0] otg_irq_register;
reg [7:0] usb_irq_register;
reg prev_sv;
reg prev_attach;
reg prev_busrst;
wire sv_fall = prev_sv & ~cmp_sess_valid;
wire sv_rise = ~prev_sv & cmp_sess_valid;
wire attach_rise = s_attach & ~prev_attach;
wire busrst_rise = s_busrst & ~prev_busrst;
wire wr_oirq = reg_wr && reg_addr == `UOTG_OFS_OTG_IRQ;
wire wr_uirq = reg_wr && reg_addr == `UOTG_OFS_USB_IRQ;
reg [7:0] next_oirq;
reg [7:0] next_uirq;

// Flags are cleared by writing a one to them.
always @* begin
    next_oirq = otg_irq_register;
    next_uirq = usb_irq_register;
    if (wr_oirq) begin
        next_oirq = next_oirq & ~reg_wdata[7:0];
    end
    if (wr_uirq) begin
        next_uirq = next_uirq & ~reg_wdata[7:0];
    end
    if (sv_fall) begin
        next_oirq[`UOTG_OI_SESS_END] = 1'b1;
    end
    if (sv_rise) begin
        next_oirq[`UOTG_OI_SESS_VALID] = 1'b1;
    end
    if (attach_rise) begin
        next_uirq[`UOTG_UI_ATTACH] = 1'b1;
    end
    if (busrst_rise) begin
        next_uirq[`UOTG_UI_BUS_RESET] = 1'b1;
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        otg_irq_register <= `UOTG_RST_BYTE;
        usb_irq_register <= `UOTG_RST_BYTE;
        prev_sv <= 1'b0;
        prev_attach <= 1'b0;
        prev_busrst <= 1'b0;
    end else begin
        otg_irq_register <= next_oirq;
        usb_irq_register <= next_uirq;
        prev_sv <= cmp_sess_valid;
        prev_attach <= s_attach;
        prev_busrst <= s_busrst;
    end
end

////////////////////////////////////////////////////////////////////////////
// Control and value registers written by software.

reg [7:0] power_ctl;
reg [7:0] descriptor_table_page;
reg [7:0] frame_count_low;
reg [2:0] frame_count_high;
reg [15:0] booster_duty_period;
reg [15:0] booster_pwm_control;

// Pull-ups, discharge, VBUS power and pulse follow software; HNP, SRP
// and reconnect sequencing are software driven through these bits.
// Control, configuration and value register writes.
always @(posedge clk) begin
    if (sys_rst) begin
        dplus_pullup_en <= 1'b0;
        dminus_pullup_en <= 1'b0;
        dplus_pulldown_en <= 1'b0;
        dminus_pulldown_en <= 1'b0;
        vbus_power_on <= 1'b0;
        otg_features_en <= 1'b0;
        vbus_charge_select <= 1'b0;
        vbus_discharge_en <= 1'b0;
        vbus_pulse_en <= 1'b0;
        internal_comparator_disable <= 1'b0;
        cmp_select <= 1'b0;
        power_ctl <= `UOTG_RST_BYTE;
        descriptor_table_page <= `UOTG_RST_BYTE;
        frame_count_low <= `UOTG_RST_BYTE;
        frame_count_high <= 3'h0;
        booster_duty_period <= `UOTG_RST_WORD;
        booster_pwm_control <= `UOTG_RST_WORD;
    end else if (reg_wr) begin
        case (reg_addr)
            `UOTG_OFS_CONTROL: begin
                dplus_pullup_en <= reg_wdata[`UOTG_CT_DP_PULLUP];
                dminus_pullup_en <= reg_wdata[`UOTG_CT_DM_PULLUP];
                dplus_pulldown_en <= reg_wdata[`UOTG_CT_DP_PULLDN];
                dminus_pulldown_en <= reg_wdata[`UOTG_CT_DM_PULLDN];
                vbus_power_on <= reg_wdata[`UOTG_CT_VBUS_ON];
                otg_features_en <= reg_wdata[`UOTG_CT_OTG_EN];
                vbus_charge_select <= reg_wdata[`UOTG_CT_VBUS_CHG];
                vbus_discharge_en <= reg_wdata[`UOTG_CT_VBUS_DIS];
            end
            `UOTG_OFS_CONFIG2: begin
                cmp_select <= reg_wdata[`UOTG_CF_CMP_SEL];
                vbus_pulse_en <= reg_wdata[`UOTG_CF_VBUS_PULSE];
                internal_comparator_disable <= reg_wdata[`UOTG_CF_CMP_DIS];
            end
            `UOTG_OFS_POWER: begin
                power_ctl <= reg_wdata[7:0] & `UOTG_PWR_MASK;
            end
            `UOTG_OFS_BDT_PAGE: begin
                descriptor_table_page <= {reg_wdata[7:1], 1'b0};
            end
            `UOTG_OFS_FRAME_LO: begin
                frame_count_low <= reg_wdata[7:0];
            end
            `UOTG_OFS_FRAME_HI: begin
                frame_count_high <= reg_wdata[2:0];
            end
            `UOTG_OFS_PWM_RRS: begin
                booster_duty_period <= reg_wdata;
            end
            `UOTG_OFS_PWM_CON: begin
                booster_pwm_control <= reg_wdata;
            end
            default: begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Read path; data stand in the cycle after the read strobe only.

reg [7:0] status_byte;
reg [15:0] next_rdata;

always @* begin
    status_byte = 8'h00;
    status_byte[`UOTG_ST_ID] = s_id;
    status_byte[`UOTG_ST_LSTABLE] = line_stable;
    status_byte[`UOTG_ST_SESS_VALID] = cmp_sess_valid;
    status_byte[`UOTG_ST_SESS_END] = cmp_sess_end;
    status_byte[`UOTG_ST_VBUS_VALID] = cmp_vbus_valid;
end

always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
        `UOTG_OFS_STATUS: next_rdata = {8'h00, status_byte};
        `UOTG_OFS_CONTROL: next_rdata = {8'h00, dplus_pullup_en,
            dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en,
            vbus_power_on, otg_features_en, vbus_charge_select,
            vbus_discharge_en};
        `UOTG_OFS_POWER: next_rdata = {8'h00, power_ctl};
        `UOTG_OFS_CONFIG2: next_rdata = {10'h000, cmp_select,
            vbus_pulse_en, 2'h0, internal_comparator_disable, 1'b0};
        `UOTG_OFS_OTG_IRQ: next_rdata = {8'h00, otg_irq_register};
        `UOTG_OFS_USB_IRQ: next_rdata = {8'h00, usb_irq_register};
        `UOTG_OFS_BDT_PAGE: next_rdata = {8'h00, descriptor_table_page};
        `UOTG_OFS_FRAME_LO: next_rdata = {8'h00, frame_count_low};
        `UOTG_OFS_FRAME_HI: next_rdata = {13'h0000, frame_count_high};
        `UOTG_OFS_PWM_RRS: next_rdata = booster_duty_period;
        `UOTG_OFS_PWM_CON: next_rdata = booster_pwm_control;
        default: next_rdata = 16'h0000;
    endcase
end

always @(posedge clk) begin
    if (sys_rst) begin
        reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= 16'h0000;
    end
end

endmodule // uotg_session_ctl

// [uotg_session_ctl_sva.sv]
// Assertion checker for the OTG session control register port.
`include "uotg_defs.vh"
module uotg_session_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [7:0] ctl_byte,
    input wire logic vbus_pulse_en,
    input wire logic internal_comparator_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Writes decode by offset; anything else must leave the pins alone.
    property p_ctl_write;
        reg_wr && reg_addr == `UOTG_OFS_CONTROL
        |=> ctl_byte == $past(reg_wdata[7:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("control pins differ from written byte");
    property p_ctl_hold;
        !(reg_wr && reg_addr == `UOTG_OFS_CONTROL) |=> $stable(ctl_byte);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold)
        else $error("control pins moved without a write");
    property p_cfg_write;
        reg_wr && reg_addr == `UOTG_OFS_CONFIG2 |=>
        vbus_pulse_en == $past(reg_wdata[4]) &&
        internal_comparator_disable == $past(reg_wdata[1]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("config pins differ from written value");
    property p_cfg_hold;
        !(reg_wr && reg_addr == `UOTG_OFS_CONFIG2) |=>
        $stable(vbus_pulse_en) && $stable(internal_comparator_disable);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("config pins moved without a write");
    // Read data shape: upper byte, idle value, fixed zero bits and control readback.
    property p_upper_zero;
        reg_rd && reg_addr != `UOTG_OFS_PWM_RRS &&
        reg_addr != `UOTG_OFS_PWM_CON |=> reg_rdata[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper byte not zero");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read answer");
    property p_status_gaps;
        reg_rd && reg_addr == `UOTG_OFS_STATUS |=>
        reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0;
    endproperty
    a_status_gaps: assert property (p_status_gaps)
        else $error("unused status bit set");
    property p_page_even;
        reg_rd && reg_addr == `UOTG_OFS_BDT_PAGE |=> reg_rdata[0] == 1'b0;
    endproperty
    a_page_even: assert property (p_page_even)
        else $error("table page bit 0 set");
    property p_frame_hi;
        reg_rd && reg_addr == `UOTG_OFS_FRAME_HI |=>
        reg_rdata[15:3] == 13'h0000;
    endproperty
    a_frame_hi: assert property (p_frame_hi)
        else $error("frame high wider than three bits");
    property p_ctl_read;
        reg_rd && reg_addr == `UOTG_OFS_CONTROL |=>
        reg_rdata == {8'h00, $past(ctl_byte)};
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control readback differs from pins");
endmodule // uotg_session_sva

// [uotg_vbus_model.sv]
// Behavioural model of the VBUS comparators that face the block.
module uotg_vbus_model (
    input wire logic [1:0] int_band,
    input wire logic [1:0] ext_band,
    output logic int_vbus_valid,
    output logic int_session_valid,
    output logic int_session_end,
    output logic comparator_status_1,
    output logic comparator_status_2,
    output logic ext_vbus_valid_in,
    output logic ext_session_valid_in,
    output logic ext_session_end_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Band 0 is below session end, band 3 above VBUS valid.
    // three-line encoding; comparator_status_1/2 carry the two-line band encoding.
    assign int_vbus_valid = &int_band;
    assign int_session_valid = int_band[1];
    assign int_session_end = int_band == 2'b00;
    assign ext_vbus_valid_in = &ext_band;
    assign ext_session_valid_in = ext_band[1];
    assign ext_session_end_in = ext_band == 2'b00;
    assign comparator_status_1 = ext_band[0];
    assign comparator_status_2 = ext_band[1];
endmodule // uotg_vbus_model

// [uotg_session_ctl_tb.sv]
// Self-checking testbench for the OTG session control block.
`include "uotg_defs.vh"
module uotg_session_ctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] int_band = 2'b00;
    logic [1:0] ext_band = 2'b00;
    logic id_pin = 1'b1;
    logic line_se0 = 1'b0;
    logic line_jstate = 1'b1;
    logic attach_event = 1'b0;
    logic bus_reset_event = 1'b0;
    wire [15:0] reg_rdata;
    wire [7:0] ctl;
    wire pulse, cmp_dis, ivv, isv, ise, st1, st2, evv, esv, ese;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [3:0] va [7] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'h2, 4'hB, 4'hA};
    logic [15:0] vd [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hA55A,
        16'hFFFF, 16'hFFFF, 16'h5AA5};
    logic [15:0] ve [7] = '{16'h00FE, 16'h00FF, 16'h0007, 16'hA55A,
        16'h0093, 16'h0000, 16'h5AA5};
    logic [15:0] cd [5] = '{16'hFFFF, 16'h0081, 16'h0000, 16'h0008,
        16'h0040};
    logic [15:0] cf [3] = '{16'h0000, 16'h0002, 16'h0022};

    always #5 clk = ~clk;

    uotg_vbus_model i_uotg_vbus_model (.int_band(int_band),
        .ext_band(ext_band), .int_vbus_valid(ivv), .int_session_valid(isv),
        .int_session_end(ise), .comparator_status_1(st1),
        .comparator_status_2(st2), .ext_vbus_valid_in(evv),
        .ext_session_valid_in(esv), .ext_session_end_in(ese));
    uotg_session_ctl i_uotg_session_ctl (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_vbus_valid(ivv),
        .int_session_valid(isv), .int_session_end(ise),
        .comparator_status_1(st1), .comparator_status_2(st2),
        .ext_vbus_valid_in(evv), .ext_session_valid_in(esv),
        .ext_session_end_in(ese), .id_pin(id_pin), .line_se0(line_se0),
        .line_jstate(line_jstate), .attach_event(attach_event),
        .bus_reset_event(bus_reset_event), .dplus_pullup_en(ctl[7]),
        .dminus_pullup_en(ctl[6]), .dplus_pulldown_en(ctl[5]),
        .dminus_pulldown_en(ctl[4]), .vbus_power_on(ctl[3]),
        .otg_features_en(ctl[2]), .vbus_charge_select(ctl[1]),
        .vbus_discharge_en(ctl[0]), .vbus_pulse_en(pulse),
        .internal_comparator_disable(cmp_dis));

    // Compare one value and keep the tallies.
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    // A write strobe lasts one cycle; one edge passes before the next
    // call, so the strobe is never lowered and raised in one time step.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp,
        input string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(what, exp, reg_rdata);
        @(posedge clk);
    endtask
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask
    // Status word for a VBUS band, ID level and a line not yet stable.
    function automatic logic [15:0] st_exp(input logic id,
        input logic [1:0] b);
        return {8'h00, id, 3'b000, b[1], b == 2'b00, 1'b0, &b};
    endfunction
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cut a hang short well beyond the few hundred cycles needed.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        int m;
        int b;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        settle();
        for (b = 1; b < 16; b++) begin
            rd(b[3:0], 16'h0000, "reset value");
        end
        for (b = 0; b < 5; b++) begin
            wr(`UOTG_OFS_CONTROL, cd[b]);
            rd(`UOTG_OFS_CONTROL, cd[b] & 16'h00FF, "control");
            chk("control pins", cd[b] & 16'h00FF, {8'h00, ctl});
        end
        for (b = 0; b < 7; b++) begin
            wr(va[b], vd[b]);
            rd(va[b], ve[b], "value reg");
        end
        wr(`UOTG_OFS_CONFIG2, 16'h0012);
        @(negedge clk);
        chk("config pins", 16'h0003, {14'h0000, pulse, cmp_dis});
        rd(`UOTG_OFS_CONFIG2, 16'h0012, "config");
        for (m = 0; m < 3; m++) begin
            for (b = 0; b < 4; b++) begin
                wr(`UOTG_OFS_CONFIG2, cf[m]);
                int_band <= (m == 0) ? b[1:0] : ~b[1:0];
                ext_band <= (m == 0) ? ~b[1:0] : b[1:0];
                id_pin <= b[0];
                line_se0 <= b[0] ^ b[1];
                settle();
                rd(`UOTG_OFS_STATUS, st_exp(b[0], b[1:0]), "status");
            end
        end
        wr(`UOTG_OFS_CONFIG2, 16'h0000);
        int_band <= 2'b10;
        settle();
        wr(`UOTG_OFS_OTG_IRQ, 16'h00FF);
        wr(`UOTG_OFS_USB_IRQ, 16'h00FF);
        int_band <= 2'b00;
        settle();
        rd(`UOTG_OFS_OTG_IRQ, 16'h0004, "otg irq");
        wr(`UOTG_OFS_OTG_IRQ, 16'h0004);
        int_band <= 2'b10;
        settle();
        rd(`UOTG_OFS_OTG_IRQ, 16'h0008, "otg irq");
        attach_event <= 1'b1;
        settle();
        bus_reset_event <= 1'b1;
        settle();
        rd(`UOTG_OFS_USB_IRQ, 16'h0041, "usb irq");
        wr(`UOTG_OFS_USB_IRQ, 16'h0041);
        rd(`UOTG_OFS_USB_IRQ, 16'h0000, "usb irq");
        wr(`UOTG_OFS_CONTROL, 16'h0088);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`UOTG_OFS_CONTROL, 16'h0000, "control after reset");
        chk("control pins after reset", 16'h0000, {8'h00, ctl});
        complete_run();
    end
endmodule // uotg_session_ctl_tb

bind uotg_session_ctl uotg_session_sva i_uotg_session_sva (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ctl_byte({dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
    dminus_pulldown_en, vbus_power_on, otg_features_en, vbus_charge_select,
    vbus_discharge_en}), .vbus_pulse_en(vbus_pulse_en),
    .internal_comparator_disable(internal_comparator_disable));
